// >>> stm_top.sv
// Standard 16-bit timer with AXI4-Lite registers and one output pin
// Assumes high and time-base clocks arrive as asynchronous tick levels
// Behaviour
// - 16-bit up counter advances on selected clock
// - P compares top byte, A all bits
// - On rising edge clears counter; no writes
// - Off stops counting and keeps value
// - Pause holds count, resume from held
// - Clock select picks one of five sources
// - Reserved clock codes stop the counter
// - Mode field selects three operating modes
// - Compare match A: none, low, high, toggle
// - PWM mode: inactive, active, PWM, single pulse
// - Requested level equal initial shows nothing
// - Turning on restores initial output level
// - Output control sets initial or active level
// - Invert bit inverts pin, not timer mode
// - Swap bit exchanges period and duty roles
// - Clear select: A match or P/overflow
// - Clear select ignored in PWM modes
// - Automatic clear raises timer interrupt request
// - Count read-only, compare A and P writable
// - Clear select high outside PWM raises only A flag
// - P period 65536 at zero, else 256n
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module stm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        high_clock,
  input  wire logic        time_base_clock,
  output logic             alternate_output_pin,
  output logic             alternate_output_pin_oe,
  output logic             timer_irq,
  output logic             compare_a_flag,
  output logic             compare_p_flag
);

  stm_pkg::stm_ctrl_t      ctrl;
  stm_pkg::stm_bus_state_t bus_state;
  stm_pkg::stm_wreq_t      wreq;
  logic [15:0] count;
  logic [15:0] compare_a_value;
  logic [7:0]  compare_p_value;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        aw_held;
  logic        w_held;
  logic        w_lane;
  logic        on_q;
  logic        on_rise;
  logic [1:0]  high_sync;
  logic [1:0]  tbc_sync;
  logic        high_prev;
  logic        tbc_prev;
  logic        high_tick;
  logic        tbc_tick;
  logic        tick;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clear_now;
  logic        pwm_mode;
  logic [15:0] period_end;
  logic [15:0] duty_value;
  logic        wave_raw;
  logic        pulse_done;
  logic        cmp_level;
  logic        next_pin;
  logic [7:0]  flag_rd;
  logic [7:0]  rd_byte;

  // ****************************************************************
  // Input synchronisers and tick edges
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_sync <= 2'h0;
      tbc_sync  <= 2'h0;
      high_prev <= 1'b0;
      tbc_prev  <= 1'b0;
    end else begin
      high_sync <= {high_sync[0], high_clock};
      tbc_sync  <= {tbc_sync[0], time_base_clock};
      high_prev <= high_sync[1];
      tbc_prev  <= tbc_sync[1];
    end
  end

  assign high_tick = high_sync[1] && !high_prev;
  assign tbc_tick  = tbc_sync[1] && !tbc_prev;

  stm_clkgen u_clkgen (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clock_select (ctrl.clock_select),
    .high_tick    (high_tick),
    .tbc_tick     (tbc_tick),
    .tick         (tick)
  );

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  assign wreq.wr   = aw_held && w_held && (bus_state == stm_pkg::STM_BUS_IDLE);
  assign wreq.addr = aw_addr;
  assign wreq.data = w_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 8'h00;
      w_lane        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wreq.wr) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end else if (wreq.wr) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_state     <= stm_pkg::STM_BUS_IDLE;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      s_axi_arready <= 1'b0;
      case (bus_state)
        stm_pkg::STM_BUS_IDLE: begin
          if (wreq.wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr > stm_pkg::STM_ADDR_FLAGS) ? 2'h2 : 2'h0;
            bus_state    <= stm_pkg::STM_BUS_WRESP;
          end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= (s_axi_araddr > stm_pkg::STM_ADDR_FLAGS) ?
                             2'h2 : 2'h0;
            bus_state     <= stm_pkg::STM_BUS_RRESP;
          end
        end
        stm_pkg::STM_BUS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_state    <= stm_pkg::STM_BUS_IDLE;
          end
        end
        stm_pkg::STM_BUS_RRESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_state    <= stm_pkg::STM_BUS_IDLE;
          end
        end
        default: bus_state <= stm_pkg::STM_BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    case (s_axi_araddr)
      stm_pkg::STM_ADDR_CTRL0: rd_byte = {ctrl.pause_control,
        ctrl.clock_select, ctrl.counter_on, 3'h0};
      stm_pkg::STM_ADDR_CTRL1: rd_byte = {ctrl.mode_field,
        ctrl.output_function, ctrl.output_control, ctrl.output_invert,
        ctrl.period_duty_swap, ctrl.clear_select};
      stm_pkg::STM_ADDR_CNTL:  rd_byte = count[7:0];
      stm_pkg::STM_ADDR_CNTH:  rd_byte = count[15:8];
      stm_pkg::STM_ADDR_CMPAL: rd_byte = compare_a_value[7:0];
      stm_pkg::STM_ADDR_CMPAH: rd_byte = compare_a_value[15:8];
      stm_pkg::STM_ADDR_CMPP:  rd_byte = compare_p_value;
      stm_pkg::STM_ADDR_FLAGS: rd_byte = flag_rd;
      default:                 rd_byte = 8'h00;
    endcase
  end

  assign flag_rd = {6'h00, compare_p_flag, compare_a_flag};

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl            <= '0;
      compare_a_value <= stm_pkg::STM_RST_WORD;
      compare_p_value <= stm_pkg::STM_RST_BYTE;
    end else if (wreq.wr && w_lane) begin
      case (wreq.addr)
        stm_pkg::STM_ADDR_CTRL0: begin
          ctrl.pause_control <= wreq.data[stm_pkg::STM_C0_PAUSE];
          ctrl.clock_select  <= wreq.data[stm_pkg::STM_C0_CKSEL_LO +: 3];
          ctrl.counter_on    <= wreq.data[stm_pkg::STM_C0_ON];
        end
        stm_pkg::STM_ADDR_CTRL1: begin
          ctrl.mode_field       <= wreq.data[stm_pkg::STM_C1_MODE_LO +: 2];
          ctrl.output_function  <= wreq.data[stm_pkg::STM_C1_OFN_LO +: 2];
          ctrl.output_control   <= wreq.data[stm_pkg::STM_C1_OC];
          ctrl.output_invert    <= wreq.data[stm_pkg::STM_C1_INV];
          ctrl.period_duty_swap <= wreq.data[stm_pkg::STM_C1_SWAP];
          ctrl.clear_select     <= wreq.data[stm_pkg::STM_C1_CLRSEL];
        end
        stm_pkg::STM_ADDR_CMPAL: compare_a_value[7:0]  <= wreq.data;
        stm_pkg::STM_ADDR_CMPAH: compare_a_value[15:8] <= wreq.data;
        stm_pkg::STM_ADDR_CMPP:  compare_p_value       <= wreq.data;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Comparators and counter
  // ****************************************************************
  assign pwm_mode = (ctrl.mode_field == stm_pkg::STM_MODE_PWM);
  assign match_a  = tick && (count == compare_a_value - 16'h0001) &&
                    (compare_a_value != 16'h0000);
  // P match every 256n ticks; no P match when P is zero
  assign match_p  = tick && (count[7:0] == 8'hFF) &&
                    (count[15:8] == compare_p_value - 8'h01) &&
                    (compare_p_value != 8'h00);
  assign overflow = tick && (count == 16'hFFFF);
  // PWM period follows swap bit instead
  always_comb begin
    if (pwm_mode) begin
      clear_now = ctrl.period_duty_swap ? match_a : (match_p || overflow);
    end else if (ctrl.clear_select) begin
      clear_now = match_a;
    end else begin
      clear_now = match_p || (overflow && compare_p_value == 8'h00);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q <= 1'b0;
    end else begin
      on_q <= ctrl.counter_on;
    end
  end

  assign on_rise = ctrl.counter_on && !on_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= stm_pkg::STM_RST_WORD;
    end else if (on_rise) begin
      count <= 16'h0000;
    end else if (ctrl.counter_on && !ctrl.pause_control && tick) begin
      count <= clear_now ? 16'h0000 : count + 16'h0001;
    end
  end

  // ****************************************************************
  // Flags and interrupt request
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
      timer_irq      <= 1'b0;
    end else begin
      if (ctrl.counter_on && !ctrl.pause_control && match_a) begin
        compare_a_flag <= 1'b1;
      end else if (wreq.wr && wreq.addr == stm_pkg::STM_ADDR_FLAGS &&
                   wreq.data[0]) begin
        compare_a_flag <= 1'b0;
      end
      // No P flag with clear select high outside PWM mode
      if (ctrl.counter_on && !ctrl.pause_control && match_p &&
          (pwm_mode || !ctrl.clear_select)) begin
        compare_p_flag <= 1'b1;
      end else if (wreq.wr && wreq.addr == stm_pkg::STM_ADDR_FLAGS &&
                   wreq.data[1]) begin
        compare_p_flag <= 1'b0;
      end
      timer_irq <= ctrl.counter_on && !ctrl.pause_control && clear_now;
    end
  end

  // ****************************************************************
  // Output waveform
  // ****************************************************************
  // Period and duty roles
  assign period_end = ctrl.period_duty_swap ? compare_a_value :
                      {compare_p_value, 8'h00};
  assign duty_value = ctrl.period_duty_swap ? {compare_p_value, 8'h00} :
                      compare_a_value;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_level  <= 1'b0;
      pulse_done <= 1'b0;
    end else if (on_rise) begin
      cmp_level  <= ctrl.output_control;
      pulse_done <= 1'b0;
    end else if (ctrl.counter_on && !ctrl.pause_control && match_a) begin
      case (ctrl.output_function)
        stm_pkg::STM_OF_1: cmp_level <= 1'b0;
        stm_pkg::STM_OF_2: cmp_level <= 1'b1;
        stm_pkg::STM_OF_3: cmp_level <= !cmp_level;
        default:           cmp_level <= cmp_level;
      endcase
      if (ctrl.counter_on && clear_now) begin
        pulse_done <= 1'b1;
      end
    end else if (ctrl.counter_on && clear_now) begin
      pulse_done <= 1'b1;
    end
  end

  assign wave_raw = ctrl.counter_on && (count < duty_value) &&
                    (period_end != 16'h0000 || 1'b1);

  always_comb begin
    case (ctrl.mode_field)
      stm_pkg::STM_MODE_CMP: next_pin = cmp_level;
      stm_pkg::STM_MODE_PWM: begin
        case (ctrl.output_function)
          stm_pkg::STM_OF_0: next_pin = !ctrl.output_control;
          stm_pkg::STM_OF_1: next_pin = ctrl.output_control;
          stm_pkg::STM_OF_2:
            next_pin = wave_raw ? ctrl.output_control : !ctrl.output_control;
          default: next_pin = (wave_raw && !pulse_done) ?
                              ctrl.output_control : !ctrl.output_control;
        endcase
      end
      default: next_pin = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alternate_output_pin    <= 1'b0;
      alternate_output_pin_oe <= 1'b0;
    end else begin
      alternate_output_pin <= next_pin ^ (ctrl.output_invert &&
                              ctrl.mode_field != stm_pkg::STM_MODE_TC);
      // Pin driven only in output modes
      alternate_output_pin_oe <= (ctrl.mode_field == stm_pkg::STM_MODE_CMP) ||
                                 pwm_mode;
    end
  end

endmodule
`default_nettype wire

// >>> stm_pkg.sv
// Package for the 16-bit standard timer: register map, fields, modes
// Assumes a 32-bit AXI4-Lite register bus, one byte register per word
package stm_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] STM_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] STM_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] STM_ADDR_CNTL  = 8'h08;
  localparam logic [7:0] STM_ADDR_CNTH  = 8'h0C;
  localparam logic [7:0] STM_ADDR_CMPAL = 8'h10;
  localparam logic [7:0] STM_ADDR_CMPAH = 8'h14;
  localparam logic [7:0] STM_ADDR_CMPP  = 8'h18;
  localparam logic [7:0] STM_ADDR_FLAGS = 8'h1C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int STM_C0_PAUSE    = 7;
  localparam int STM_C0_CKSEL_LO = 4;
  localparam int STM_C0_ON       = 3;
  localparam int STM_C1_MODE_LO  = 6;
  localparam int STM_C1_OFN_LO   = 4;
  localparam int STM_C1_OC       = 3;
  localparam int STM_C1_INV      = 2;
  localparam int STM_C1_SWAP     = 1;
  localparam int STM_C1_CLRSEL   = 0;
  localparam logic [7:0] STM_C0_WMASK = 8'hF8;
  localparam logic [7:0] STM_RST_BYTE = 8'h00;
  localparam logic [15:0] STM_RST_WORD = 16'h0000;

  // ****************************************************************
  // Clock select codes and divider counts
  // ****************************************************************
  localparam logic [2:0] STM_CK_SYS4 = 3'h0;
  localparam logic [2:0] STM_CK_SYS  = 3'h1;
  localparam logic [2:0] STM_CK_H16  = 3'h2;
  localparam logic [2:0] STM_CK_H64  = 3'h3;
  localparam logic [2:0] STM_CK_TBC  = 3'h4;
  localparam logic [5:0] STM_DIV4_LAST  = 6'h03;
  localparam logic [5:0] STM_DIV16_LAST = 6'h0F;
  localparam logic [5:0] STM_DIV64_LAST = 6'h3F;

  // ****************************************************************
  // Modes and output functions
  // ****************************************************************
  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TC  = 2'h3;
  localparam logic [1:0] STM_OF_0 = 2'h0;
  localparam logic [1:0] STM_OF_1 = 2'h1;
  localparam logic [1:0] STM_OF_2 = 2'h2;
  localparam logic [1:0] STM_OF_3 = 2'h3;

  typedef enum logic [1:0] {
    STM_BUS_IDLE,
    STM_BUS_WRESP,
    STM_BUS_RRESP
  } stm_bus_state_t;

  typedef struct packed {
    logic       pause_control;
    logic [2:0] clock_select;
    logic       counter_on;
    logic [1:0] mode_field;
    logic [1:0] output_function;
    logic       output_control;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_select;
  } stm_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  data;
  } stm_wreq_t;

endpackage

// >>> stm_clkgen.sv
// Counter tick generator: turns the chosen clock source into a pulse
// Assumes time-base tick arrives synchronised to aclk
`timescale 1ns/1ps
`default_nettype none
module stm_clkgen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clock_select,
  input  wire logic       high_tick,
  input  wire logic       tbc_tick,
  output logic            tick
);

  logic [5:0] sys_div;
  logic [5:0] h_div;

  // ****************************************************************
  // Dividers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div <= 6'h00;
    end else if (sys_div == stm_pkg::STM_DIV4_LAST) begin
      sys_div <= 6'h00;
    end else begin
      sys_div <= sys_div + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_div <= 6'h00;
    end else if (high_tick) begin
      h_div <= h_div + 6'h01;
    end
  end

  // ****************************************************************
  // Source select
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      case (clock_select)
        stm_pkg::STM_CK_SYS4: tick <= (sys_div == stm_pkg::STM_DIV4_LAST);
        stm_pkg::STM_CK_SYS:  tick <= 1'b1;
        stm_pkg::STM_CK_H16:
          tick <= high_tick && (h_div[3:0] == stm_pkg::STM_DIV16_LAST[3:0]);
        stm_pkg::STM_CK_H64:
          tick <= high_tick && (h_div == stm_pkg::STM_DIV64_LAST);
        stm_pkg::STM_CK_TBC:  tick <= tbc_tick;
        default:              tick <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> stm_asserts.sv
// Checker for the standard timer bus handshake and timer interrupt output
// Assumes binding onto stm_top; sees a subset of its ports only
`timescale 1ns/1ps
`default_nettype none
module stm_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_irq
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  irq_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("timer irq longer than one cycle");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  rd_answer_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read address taken without data");
  rd_unmapped_a: assert property (s_axi_arready && s_axi_araddr > 8'h1C
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  rd_byte_only_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  wr_resp_a: assert property (s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  wr_unmapped_a: assert property (s_axi_awready &&
    s_axi_awaddr > 8'h1C |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2))
    else $error("unmapped write not refused");
endmodule
bind stm_top stm_asserts u_stm_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_irq(timer_irq));
`default_nettype wire

// >>> tb_stm_top.sv
// Testbench for the standard timer: registers, clocks, modes
// Assumes stm_pkg and stm_top compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_stm_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wready;
  logic        s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, high_clock;
  logic        time_base_clock, pin, pin_oe, timer_irq, fl_a, fl_p;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, x;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_b, last_r;
  int          errors, tests_run, seed, n, m, v, w, a, e, h;
  int          divs[7] = '{4, 1, 256, 1024, 8, 0, 0};
  stm_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .high_clock(high_clock),
    .time_base_clock(time_base_clock), .alternate_output_pin(pin),
    .alternate_output_pin_oe(pin_oe), .timer_irq(timer_irq),
    .compare_a_flag(fl_a), .compare_p_flag(fl_p));
  // ****************************************************************
  // Clocks
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    high_clock = 1'b0;
    #1.3;
    forever #32 high_clock = ~high_clock;
  end
  initial begin
    time_base_clock = 1'b0;
    #0.7;
    forever #16 time_base_clock = ~time_base_clock;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out();
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      errors++;
      close_out();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] val);
    int k;
    k = 0;
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= {24'h0, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 50);
    last_b = s_axi_bresp;
    bound(k, 50);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    int k;
    k = 0;
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 50);
    q = s_axi_rdata;
    last_r = s_axi_rresp;
    bound(k, 50);
    @(posedge aclk);
  endtask
  task automatic rd_cnt(output int c);
    rd(stm_pkg::STM_ADDR_CNTL, d);
    c = d[7:0];
    rd(stm_pkg::STM_ADDR_CNTH, d);
    c = c + 256 * d[7:0];
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!timer_irq && k < 2000);
    bound(k, 2000);
  endtask
  task automatic setup(input logic [7:0] c1, input int av, input int pv);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h10);
    wr(stm_pkg::STM_ADDR_FLAGS, 8'h03);
    wr(stm_pkg::STM_ADDR_CTRL1, c1);
    wr(stm_pkg::STM_ADDR_CMPAL, av[7:0]);
    wr(stm_pkg::STM_ADDR_CMPAH, av[15:8]);
    wr(stm_pkg::STM_ADDR_CMPP, pv[7:0]);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h18);
    repeat (3) @(posedge aclk);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    errors = 0;
    tests_run = 0;
    seed = 89052;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      rd(8'(4 * i), d);
      chk(d, 32'h0);
      chk(last_r, (i == 8) ? 2'h2 : 2'h0);
    end
    wr(8'h20, 8'h5A);
    chk(last_b, 2'h2);
    x = 8'($random(seed));
    wr(stm_pkg::STM_ADDR_CMPP, x);
    rd(stm_pkg::STM_ADDR_CMPP, d);
    chk(d, {24'h0, x});
    // Rate per clock source, clear on switch-on, hold when off
    setup(8'hC1, 16'hFFFF, 0);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h00);
    for (int c = 0; c < 7; c++) begin
      wr(stm_pkg::STM_ADDR_CTRL0, 8'(16 * c + 8));
      repeat (4096) @(posedge aclk);
      wr(stm_pkg::STM_ADDR_CTRL0, 8'(16 * c));
      rd_cnt(v);
      w = (divs[c] == 0) ? 0 : 4096 / divs[c] - 1;
      e = (divs[c] == 0) ? 0 : 4112 / divs[c] + 1;
      chk(v >= w && v <= e, 1'b1);
      wr(stm_pkg::STM_ADDR_CNTL, 8'hFF);
      rd_cnt(w);
      chk(w, v);
    end
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h18);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h98);
    rd_cnt(v);
    repeat (200) @(posedge aclk);
    rd_cnt(w);
    chk(w, v);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h18);
    repeat (100) @(posedge aclk);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h10);
    rd_cnt(w);
    chk(w >= v + 100 && w <= v + 115, 1'b1);
    // Compare match output for every output function
    for (int f = 0; f < 4; f++) begin
      h = $random(seed);
      a = 256 + h[15:8]; // never zero
      setup({2'h0, 2'(f), h[0], h[1], 2'h1}, a, 1);
      chk(pin, h[0] ^ h[1]);
      chk(pin_oe, 1'b1);
      wait_irq(n);
      repeat (3) @(posedge aclk);
      e = (f == 0) ? h[0] : (f == 3) ? !h[0] : f - 1;
      chk(pin, 1'(e) ^ h[1]);
      wait_irq(m);
      chk(m, a - 3);
      rd(stm_pkg::STM_ADDR_FLAGS, d);
      chk(d, 32'h1);
    end
    // Timer mode cleared by compare P
    setup(8'hC0, 16'h0300, 1);
    wait_irq(n);
    wait_irq(m);
    chk(m, 256);
    chk(pin_oe, 1'b0);
    rd(stm_pkg::STM_ADDR_FLAGS, d);
    chk(d, 32'h2);
    // PWM duty, swapped roles, forced levels
    for (int f = 2; f < 4; f++) begin
      setup({2'h2, 2'(f), 4'h8}, 16'h0040, 1);
      wait_irq(n);
      h = 0;
      repeat (256) @(posedge aclk) h += pin;
      chk(h, (f == 2) ? 64 : 0);
    end
    setup(8'hAA, 16'h0080, 1);
    wait_irq(n);
    wait_irq(m);
    chk(m, 128);
    for (int f = 0; f < 2; f++) begin
      h = $random(seed);
      setup({2'h2, 2'(f), h[0], 3'h0}, 16'h0040, 1);
      chk(pin, f[0] ? h[0] : !h[0]);
    end
    close_out();
  end
endmodule
`default_nettype wire
